// *** dv/fbk_flags_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbk_flags_sva
    import fbk_flags_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic update,
    input wire loop_sample_t loop1_in,
    input wire loop_sample_t loop2_in,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic loop1_error_excess_flag,
    input wire logic loop2_error_excess_flag,
    input wire logic loop1_feedback_window_flag,
    input wire logic loop2_feedback_window_flag
);
    // No level can be set above 100.00 percent, so anything beyond it settles a flag.
    localparam logic signed [16:0] TOP = 17'sh02710;
    wire logic signed [16:0] err1 = 17'(loop1_in.target) - 17'(loop1_in.feedback);
    wire logic signed [16:0] err2 = 17'(loop2_in.target) - 17'(loop2_in.feedback);
    wire logic big1 = err1 > TOP || err1 < -TOP;
    wire logic big2 = err2 > TOP || err2 < -TOP;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_reset_flag_values: assert property ($fell(rst) |-> loop1_feedback_window_flag
        && loop2_feedback_window_flag && !loop1_error_excess_flag && !loop2_error_excess_flag)
        else $error("flags wrong after reset");
    a_flags_hold_between: assert property (!$past(update) && !$past(rst) |->
        $stable(loop1_error_excess_flag) && $stable(loop2_error_excess_flag) &&
        $stable(loop1_feedback_window_flag) && $stable(loop2_feedback_window_flag))
        else $error("flag moved without an update");
    a_zero_error_quiet: assert property (update && err1 == 0 |=> !loop1_error_excess_flag)
        else $error("excess flag with zero error");
    a_big_error_one: assert property (update && big1 |=> loop1_error_excess_flag)
        else $error("loop one excess flag missing");
    a_big_error_two: assert property (update && big2 |=> loop2_error_excess_flag)
        else $error("loop two excess flag missing");
    a_window_clear_one: assert property (update && loop1_in.feedback > TOP |=>
        !loop1_feedback_window_flag) else $error("loop one compare flag not cleared");
    a_window_clear_two: assert property (update && loop2_in.feedback > TOP |=>
        !loop2_feedback_window_flag) else $error("loop two compare flag not cleared");
    a_bus_always_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or error response");
endmodule
`default_nettype wire

// *** dv/loop_source.sv ***
`timescale 1ns/1ps
`default_nettype none
module loop_source
    import fbk_flags_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire loop_sample_t l1_want,
    input wire loop_sample_t l2_want,
    output var logic update,
    output var loop_sample_t loop1_in,
    output var loop_sample_t loop2_in
);
    // One sample every fourth cycle; between samples the lines carry junk, so a design
    // that looks at them without the strobe is caught.
    logic [1:0] cnt_reg;
    always_ff @(posedge clk_sys) begin
        cnt_reg <= rst ? 2'h0 : cnt_reg + 2'h1;
        update <= !rst && cnt_reg == 2'h3;
        loop1_in <= (cnt_reg == 2'h3) ? l1_want : ~l1_want;
        loop2_in <= (cnt_reg == 2'h3) ? l2_want : ~l2_want;
    end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fbk_flags_pkg::*;
    logic clk_sys = 1'b0;
    logic rst, hsel, hwrite, hreadyout, hresp, irq, update;
    logic [1:0] htrans, terminal_out;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic loop1_error_excess_flag, loop2_error_excess_flag;
    logic loop1_feedback_window_flag, loop2_feedback_window_flag;
    logic signed [16:0] loop1_error_monitor, loop2_error_monitor;
    logic signed [15:0] loop2_feedback_monitor;
    loop_sample_t loop1_in, loop2_in, w1v, w2v;
    int n_fail = 0;
    int samples_checked = 0;
    int i;
    logic [15:0] rst_tab [10] = '{EXCESS_LEVEL_RST, EXCESS_LEVEL_RST, CLEAR_THR_RST, SET_THR_RST,
        CLEAR_THR_RST, SET_THR_RST, PGAIN_RST, ITIME_RST, DTIME_RST, 16'h0000};
    localparam logic [3:0] TBITS = 4'h9;
    wire logic [3:0] flags = {loop2_feedback_window_flag, loop1_feedback_window_flag,
        loop2_error_excess_flag, loop1_error_excess_flag};
    always #5 clk_sys = ~clk_sys;
    fbk_flags dut_u (.clk_sys, .rst, .update, .loop1_in, .loop2_in, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq,
        .terminal_out, .loop1_error_excess_flag, .loop2_error_excess_flag,
        .loop1_feedback_window_flag, .loop2_feedback_window_flag, .loop1_error_monitor,
        .loop2_error_monitor, .loop2_feedback_monitor);
    loop_source src_u (.clk_sys, .rst, .l1_want(w1v), .l2_want(w2v), .update, .loop1_in,
        .loop2_in);
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // A zero-wait slave is assumed by nobody here; the loop bounds every wait.
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rdv = hrdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    task automatic feed(input logic [15:0] t1, f1, t2, f2, input logic [3:0] e);
        w1v <= {t1, f1};
        w2v <= {t2, f2};
        repeat (10) @(posedge clk_sys);
        chk({28'h0, flags}, {28'h0, e});
    endtask
    task automatic term_scan(input logic [3:0] tbits);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, OFS_SELECT, {16'h0, {2{FN_LOOP1_EXCESS + 8'(k)}}});
            repeat (3) @(posedge clk_sys);
            chk({30'h0, terminal_out}, {30'h0, {2{tbits[k]}}});
        end
    endtask
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        w1v = '0;
        w2v = '0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk({28'h0, flags}, 32'h0000000C);
        for (i = 0; i < 10; i++) begin
            rdc(8'(4 * i), {16'h0, rst_tab[i]});
        end
        rdc(8'h3C, 32'h0);
        bus(1'b1, OFS_PGAIN, 32'hFFFF);
        rdc(OFS_PGAIN, {16'h0, PGAIN_MAX});
        $display("test defaults done");
        feed(16'h012C, 16'h0, 16'h0, 16'h0, 4'hC);
        feed(16'h0, 16'h012D, 16'h0, 16'h0, 4'hD);
        bus(1'b1, OFS_L2_EXCESS, 32'h3E8);
        feed(16'h0200, 16'h0, 16'h0200, 16'h0, 4'hD);
        feed(16'h0, 16'h0, 16'h03E9, 16'h0, 4'hE);
        bus(1'b1, OFS_SIGN, 32'h1);
        feed(16'h0, 16'h0, 16'h0064, 16'h0, 4'hC);
        chk({15'h0, loop2_error_monitor}, 32'h0001FF9C);
        $display("test excess done");
        bus(1'b1, OFS_L1_CLEAR, 32'h1388);
        bus(1'b1, OFS_L1_SET, 32'h07D0);
        feed(16'h0, 16'h0BB8, 16'h0, 16'h0, 4'hD);
        feed(16'h0, 16'h1389, 16'h0, 16'h0, 4'h9);
        feed(16'h0, 16'h0BB8, 16'h0, 16'h0, 4'h9);
        feed(16'h0, 16'h07CF, 16'h0, 16'h0, 4'hD);
        bus(1'b1, OFS_L1_SET, 32'h1770);
        feed(16'h0, 16'h157C, 16'h0, 16'h0, 4'h9);
        feed(16'h0, 16'h03E8, 16'h0, 16'h0, 4'hD);
        bus(1'b1, OFS_L1_CLEAR, 32'h0);
        bus(1'b1, OFS_L1_SET, 32'h0);
        feed(16'h0, 16'h03E8, 16'h0, 16'h0, 4'h9);
        $display("test window done");
        term_scan(TBITS);
        $display("test terminals done");
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        rdc(OFS_IRQ_STAT, 32'h7);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, OFS_IRQ_MASK, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, OFS_IRQ_STAT, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        rdc(OFS_IRQ_STAT, 32'h6);
        $display("test interrupt done");
        feed(16'h0, 16'h2711, 16'hD8F0, 16'h2711, 4'h3);
        chk({15'h0, loop1_error_monitor}, 32'h0001D8EF);
        rdc(OFS_MONITOR, 32'h00002711);
        $display("test limits done");
        bus(1'b1, OFS_L2_CLEAR, 32'h1388);
        bus(1'b1, OFS_L2_SET, 32'h07D0);
        feed(16'h0, 16'h0, 16'h0, 16'h0BB8, 4'h2);
        term_scan(4'h4);
        feed(16'h0, 16'h0, 16'h0, 16'h07CF, 4'hA);
        $display("test loop two window done");
        report_and_stop();
    end
endmodule
bind fbk_flags fbk_flags_sva chk_u (.clk_sys, .rst, .update, .loop1_in, .loop2_in, .hreadyout,
    .hresp, .loop1_error_excess_flag, .loop2_error_excess_flag, .loop1_feedback_window_flag,
    .loop2_feedback_window_flag);
`default_nettype wire

// *** logic/fbk_flags.sv ***
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Loop-1 excess flag rises when loop-1 error passes its level, default 3.00 percent.
// - Loop-2 excess flag uses its own level, default 3.00 percent.
// - Terminal select 045 gives loop-1 excess flag, 047 gives loop-2 excess flag.
// - Feedback-compare flag clears when feedback rises above that loop's OFF threshold.
// - Once cleared, it sets again only when feedback drops below the ON threshold.
// - With OFF threshold below ON threshold, clearing beats setting.
// - Feedback compare works only when ON or OFF threshold is nonzero.
// - From start, feedback-compare flag stays on until feedback first exceeds OFF.
// - Loop-1 thresholds span 0 to 100.00 percent, OFF resets 100.00, ON 0.00.
// - Loop-2 thresholds are separate, OFF resets 100.00, ON resets 0.00.
// - Loop-2 proportional gain spans 0.0 to 100.0, resets to 1.0.
// - Loop-2 integral time spans 0.0 to 3600.0 s, resets to 1.0 s.
// - Loop-2 derivative time spans 0.00 to 100.00 s, resets to 0.00.
// - Loop-2 error is target minus feedback at 00, feedback minus target at 01.
module fbk_flags
    import fbk_flags_pkg::*;
#(
    parameter int TERMS = N_TERM
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic update,
    input wire loop_sample_t loop1_in,
    input wire loop_sample_t loop2_in,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    output logic [TERMS-1:0] terminal_out,
    output logic loop1_error_excess_flag,
    output logic loop2_error_excess_flag,
    output logic loop1_feedback_window_flag,
    output logic loop2_feedback_window_flag,
    output logic signed [16:0] loop1_error_monitor,
    output logic signed [16:0] loop2_error_monitor,
    output logic signed [15:0] loop2_feedback_monitor
);
    logic [15:0] loop1_error_excess_level_reg;
    logic [15:0] loop2_error_excess_level_reg;
    window_cfg_t loop1_cfg_reg;
    window_cfg_t loop2_cfg_reg;
    logic [15:0] loop2_proportional_gain_reg;
    logic [15:0] loop2_integral_time_reg;
    logic [15:0] loop2_derivative_time_reg;
    logic [1:0] loop2_error_sign_invert_reg;
    logic [7:0] output_terminal_function_select_reg [TERMS];
    logic [3:0] irq_stat_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] flags_prev_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;

    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] hi);
        clamp = (v > hi) ? hi : v;
    endfunction

    function automatic logic [16:0] magnitude(input logic signed [16:0] e);
        magnitude = e[16] ? 17'(-e) : e;
    endfunction

    function automatic logic window_next(input logic cur, input logic signed [15:0] fb,
                                         input window_cfg_t c);
        logic active;
        active = (c.clear_thr != 16'h0000) || (c.set_thr != 16'h0000);
        if (!active) begin
            window_next = 1'b0;
        end else if (fb > c.clear_thr) begin
            window_next = 1'b0;
        end else if (fb < c.set_thr) begin
            window_next = 1'b1;
        end else begin
            window_next = cur;
        end
    endfunction

    wire logic signed [16:0] err1 = 17'(loop1_in.target) - 17'(loop1_in.feedback);
    wire logic signed [16:0] err2_plain = 17'(loop2_in.target) - 17'(loop2_in.feedback);
    wire logic signed [16:0] err2 = (loop2_error_sign_invert_reg == SIGN_INVERT) ?
        17'(-err2_plain) : err2_plain;
    wire logic excess1 = magnitude(err1) > {1'b0, loop1_error_excess_level_reg};
    wire logic excess2 = magnitude(err2) > {1'b0, loop2_error_excess_level_reg};
    wire logic win1 = window_next(loop1_feedback_window_flag, loop1_in.feedback, loop1_cfg_reg);
    wire logic win2 = window_next(loop2_feedback_window_flag, loop2_in.feedback, loop2_cfg_reg);
    wire logic [3:0] flags = {loop2_feedback_window_flag, loop1_feedback_window_flag,
                              loop2_error_excess_flag, loop1_error_excess_flag};
    wire logic [3:0] rise = flags & ~flags_prev_reg;

    // Bus decode: writes land one cycle after the address phase, zero wait states.
    wire logic addr_ok = hsel && htrans[1] && hready;
    wire logic wr_take = addr_ok && hwrite;
    wire logic rd_take = addr_ok && !hwrite;
    wire logic [7:0] ofs = {haddr[7:2], 2'b00};
    wire logic [15:0] wd = hwdata[15:0];
    wire logic do_wr = wr_pend_reg;
    wire logic [3:0] stat_clear = (do_wr && wr_addr_reg == OFS_IRQ_STAT) ? hwdata[3:0] : 4'h0;
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (ofs == OFS_L1_EXCESS) begin
            rd_mux = {16'h0000, loop1_error_excess_level_reg};
        end else if (ofs == OFS_L2_EXCESS) begin
            rd_mux = {16'h0000, loop2_error_excess_level_reg};
        end else if (ofs == OFS_L1_CLEAR) begin
            rd_mux = {16'h0000, loop1_cfg_reg.clear_thr};
        end else if (ofs == OFS_L1_SET) begin
            rd_mux = {16'h0000, loop1_cfg_reg.set_thr};
        end else if (ofs == OFS_L2_CLEAR) begin
            rd_mux = {16'h0000, loop2_cfg_reg.clear_thr};
        end else if (ofs == OFS_L2_SET) begin
            rd_mux = {16'h0000, loop2_cfg_reg.set_thr};
        end else if (ofs == OFS_PGAIN) begin
            rd_mux = {16'h0000, loop2_proportional_gain_reg};
        end else if (ofs == OFS_ITIME) begin
            rd_mux = {16'h0000, loop2_integral_time_reg};
        end else if (ofs == OFS_DTIME) begin
            rd_mux = {16'h0000, loop2_derivative_time_reg};
        end else if (ofs == OFS_SIGN) begin
            rd_mux = {30'h0000_0000, loop2_error_sign_invert_reg};
        end else if (ofs == OFS_SELECT) begin
            rd_mux = {16'h0000, output_terminal_function_select_reg[1],
                      output_terminal_function_select_reg[0]};
        end else if (ofs == OFS_FLAGS) begin
            rd_mux = {28'h000_0000, flags};
        end else if (ofs == OFS_IRQ_STAT) begin
            rd_mux = {28'h000_0000, irq_stat_reg};
        end else if (ofs == OFS_IRQ_MASK) begin
            rd_mux = {28'h000_0000, irq_mask_reg};
        end else if (ofs == OFS_MONITOR) begin
            rd_mux = {16'h0000, loop2_feedback_monitor};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_reg <= wr_take;
            wr_addr_reg <= ofs;
            hrdata <= rd_take ? rd_mux : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            loop1_error_excess_level_reg <= EXCESS_LEVEL_RST;
            loop2_error_excess_level_reg <= EXCESS_LEVEL_RST;
            loop1_cfg_reg <= '{clear_thr: CLEAR_THR_RST, set_thr: SET_THR_RST};
            loop2_cfg_reg <= '{clear_thr: CLEAR_THR_RST, set_thr: SET_THR_RST};
            loop2_proportional_gain_reg <= PGAIN_RST;
            loop2_integral_time_reg <= ITIME_RST;
            loop2_derivative_time_reg <= DTIME_RST;
            loop2_error_sign_invert_reg <= SIGN_NORMAL;
            irq_mask_reg <= 4'h0;
        end else if (do_wr) begin
            // Out-of-range levels, thresholds, gain and times saturate rather than being refused; the sign field stores any two-bit value as written.
            if (wr_addr_reg == OFS_L1_EXCESS) begin
                loop1_error_excess_level_reg <= clamp(wd, PCT_MAX);
            end else if (wr_addr_reg == OFS_L2_EXCESS) begin
                loop2_error_excess_level_reg <= clamp(wd, PCT_MAX);
            end else if (wr_addr_reg == OFS_L1_CLEAR) begin
                loop1_cfg_reg.clear_thr <= clamp(wd, PCT_MAX);
            end else if (wr_addr_reg == OFS_L1_SET) begin
                loop1_cfg_reg.set_thr <= clamp(wd, PCT_MAX);
            end else if (wr_addr_reg == OFS_L2_CLEAR) begin
                loop2_cfg_reg.clear_thr <= clamp(wd, PCT_MAX);
            end else if (wr_addr_reg == OFS_L2_SET) begin
                loop2_cfg_reg.set_thr <= clamp(wd, PCT_MAX);
            end else if (wr_addr_reg == OFS_PGAIN) begin
                loop2_proportional_gain_reg <= clamp(wd, PGAIN_MAX);
            end else if (wr_addr_reg == OFS_ITIME) begin
                loop2_integral_time_reg <= clamp(wd, ITIME_MAX);
            end else if (wr_addr_reg == OFS_DTIME) begin
                loop2_derivative_time_reg <= clamp(wd, DTIME_MAX);
            end else if (wr_addr_reg == OFS_SIGN) begin
                loop2_error_sign_invert_reg <= hwdata[1:0];
            end else if (wr_addr_reg == OFS_IRQ_MASK) begin
                irq_mask_reg <= hwdata[3:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            output_terminal_function_select_reg[0] <= 8'h00;
            output_terminal_function_select_reg[1] <= 8'h00;
        end else if (do_wr && wr_addr_reg == OFS_SELECT) begin
            output_terminal_function_select_reg[0] <= hwdata[7:0];
            output_terminal_function_select_reg[1] <= hwdata[15:8];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            loop1_error_excess_flag <= 1'b0;
            loop2_error_excess_flag <= 1'b0;
            loop1_feedback_window_flag <= 1'b1;
            loop2_feedback_window_flag <= 1'b1;
            loop1_error_monitor <= 17'h0_0000;
            loop2_error_monitor <= 17'h0_0000;
            loop2_feedback_monitor <= 16'h0000;
        end else if (update) begin
            loop1_error_excess_flag <= excess1;
            loop2_error_excess_flag <= excess2;
            loop1_feedback_window_flag <= win1;
            loop2_feedback_window_flag <= win2;
            loop1_error_monitor <= err1;
            loop2_error_monitor <= err2;
            loop2_feedback_monitor <= loop2_in.feedback;
        end
    end

    // Status bits latch rising flag edges; a new edge wins over a same-cycle clear.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // Same levels as the flags come out of reset with, so no false rise is logged.
            flags_prev_reg <= 4'hC;
            irq_stat_reg <= 4'h0;
            irq <= 1'b0;
        end else begin
            flags_prev_reg <= flags;
            irq_stat_reg <= (irq_stat_reg & ~stat_clear) | rise;
            irq <= |(((irq_stat_reg & ~stat_clear) | rise) & irq_mask_reg);
        end
    end

    wire logic [TERMS-1:0] term_next;

    genvar t;
    generate
        for (t = 0; t < TERMS; t++) begin : g_term
            wire logic [7:0] sel = output_terminal_function_select_reg[t];
            assign term_next[t] = (sel == FN_LOOP1_EXCESS) ? excess_now(0) :
                                  (sel == FN_LOOP2_EXCESS) ? excess_now(1) :
                                  (sel == FN_LOOP1_WINDOW) ? excess_now(2) :
                                  (sel == FN_LOOP2_WINDOW) ? excess_now(3) : 1'b0;
        end
    endgenerate

    // One process owns the whole terminal vector, so each bit has a single driver.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            terminal_out <= '0;
        end else begin
            terminal_out <= term_next;
        end
    end

    function automatic logic excess_now(input int i);
        excess_now = flags[i];
    endfunction
endmodule
`default_nettype wire

// *** logic/fbk_flags_pkg.sv ***
package fbk_flags_pkg;
    // Percent values are hundredths of a percent, signed 16-bit.
    localparam int PCT_W = 16;
    localparam logic [15:0] EXCESS_LEVEL_RST = 16'h012C;
    localparam logic [15:0] CLEAR_THR_RST = 16'h2710;
    localparam logic [15:0] SET_THR_RST = 16'h0000;
    localparam logic [15:0] PCT_MAX = 16'h2710;
    // Gains: proportional in tenths, integral in tenths of a second, derivative in hundredths.
    localparam logic [15:0] PGAIN_RST = 16'h000A;
    localparam logic [15:0] PGAIN_MAX = 16'h03E8;
    localparam logic [15:0] ITIME_RST = 16'h000A;
    localparam logic [15:0] ITIME_MAX = 16'h8CA0;
    localparam logic [15:0] DTIME_RST = 16'h0000;
    localparam logic [15:0] DTIME_MAX = 16'h2710;
    localparam logic [7:0] FN_LOOP1_EXCESS = 8'h2D;
    localparam logic [7:0] FN_LOOP1_WINDOW = 8'h2E;
    localparam logic [7:0] FN_LOOP2_EXCESS = 8'h2F;
    localparam logic [7:0] FN_LOOP2_WINDOW = 8'h30;
    localparam logic [1:0] SIGN_NORMAL = 2'h0;
    localparam logic [1:0] SIGN_INVERT = 2'h1;
    // AHB-Lite byte offsets.
    localparam logic [7:0] OFS_L1_EXCESS = 8'h00;
    localparam logic [7:0] OFS_L2_EXCESS = 8'h04;
    localparam logic [7:0] OFS_L1_CLEAR = 8'h08;
    localparam logic [7:0] OFS_L1_SET = 8'h0C;
    localparam logic [7:0] OFS_L2_CLEAR = 8'h10;
    localparam logic [7:0] OFS_L2_SET = 8'h14;
    localparam logic [7:0] OFS_PGAIN = 8'h18;
    localparam logic [7:0] OFS_ITIME = 8'h1C;
    localparam logic [7:0] OFS_DTIME = 8'h20;
    localparam logic [7:0] OFS_SIGN = 8'h24;
    localparam logic [7:0] OFS_SELECT = 8'h28;
    localparam logic [7:0] OFS_FLAGS = 8'h2C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
    localparam logic [7:0] OFS_MONITOR = 8'h38;
    localparam int N_TERM = 2;
    localparam int FLAG_L1_EXCESS = 0;
    localparam int FLAG_L2_EXCESS = 1;
    localparam int FLAG_L1_WINDOW = 2;
    localparam int FLAG_L2_WINDOW = 3;
    typedef struct packed {
        logic signed [15:0] target;
        logic signed [15:0] feedback;
    } loop_sample_t;
    typedef struct packed {
        logic signed [15:0] clear_thr;
        logic signed [15:0] set_thr;
    } window_cfg_t;
endpackage
